/* design/csr_charger_status.v */
`timescale 1ns/1ns
`include "csr_regs.vh"
// Status, detail, mask and configuration bank of the charger.
module csr_charger_status #(
    parameter [22:0] QUAL_LONG = `CSR_QUAL_LONG_CYC,
    parameter [22:0] QUAL_SHORT = `CSR_QUAL_SHORT_CYC
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst,
    // Register port from the serial interface.
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    // Analog and state machine conditions.
    input wire i_aicl_active,
    input wire [1:0] i_input_detail_code,
    input wire i_input_at_limit,
    input wire i_charge_suspended,
    input wire i_thermal_regulation_flag,
    input wire i_batt_disconnect_pin,
    input wire i_batt_switch_disable_bit,
    input wire [1:0] i_remote_sense_detail,
    input wire i_batt_removed,
    input wire i_batt_timer_fault,
    input wire i_batt_prequal,
    input wire i_batt_low,
    input wire i_batt_overvolt,
    input wire i_batt_overcurrent,
    input wire i_deep_suspend,
    input wire [3:0] i_charge_state_code,
    input wire i_watchdog_expired,
    input wire i_guideline_ctrl,
    input wire i_suspend_pin,
    input wire [2:0] i_thermistor_detail_code,
    input wire i_otg_ilim,
    input wire i_boost_ilim,
    input wire i_buck_neg_ilim,
    input wire i_boost_done,
    // Configuration outputs.
    output wire [1:0] o_spread_envelope_sel,
    output wire o_spread_pattern_sel,
    output wire o_removal_detect_mask,
    output wire o_charger_en,
    output wire o_buck_en,
    // Combined interrupt.
    output wire o_irq
);
    reg [7:0] irq_mask_ff;
    reg [7:0] cfg0_ff;
    reg [7:0] live_prev_ff;
    reg live_init_ff;
    wire batt_oc_seen_w;
    wire qual_inlim;
    wire qual_ov;
    wire qual_oc;
    wire qual_boost;
    wire otg_mode;
    wire input_present;
    wire rd_latch;
    wire rd_det1;
    wire rd_det2;
    wire [3:0] byp_code;
    reg [2:0] bat_code;
    reg [3:0] chg_code;
    wire [7:0] live;
    wire [7:0] latch;
    wire [7:0] det0;
    wire [7:0] det1;
    wire [7:0] det2;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------

    // True when a read strobe targets the given address.
    function rd_hit;
        input [7:0] addr;
        input rd;
        input [7:0] target;
        begin
            rd_hit = rd && (addr == target);
        end
    endfunction

    assign rd_latch = rd_hit(i_addr, i_rd, `CSR_ADDR_IRQ_LATCH);
    assign rd_det1 = rd_hit(i_addr, i_rd, `CSR_ADDR_DET1);
    assign rd_det2 = rd_hit(i_addr, i_rd, `CSR_ADDR_DET2);

    // ---------------------------------------------------------------
    // Writable registers
    // ---------------------------------------------------------------

    // Mask and configuration registers, written by the host.
    always @(posedge i_clk) begin
        if (i_rst) begin
            irq_mask_ff <= `CSR_RST_IRQ_MASK;
            cfg0_ff <= `CSR_RST_CFG0;
        end else if (i_wr && i_addr == `CSR_ADDR_IRQ_MASK) begin
            irq_mask_ff <= i_wdata;
        end else if (i_wr && i_addr == `CSR_ADDR_CFG0) begin
            cfg0_ff <= i_wdata;
        end
    end

    assign o_spread_envelope_sel = cfg0_ff[7:6];
    assign o_spread_pattern_sel = cfg0_ff[5];
    assign o_removal_detect_mask = cfg0_ff[4];
    assign o_charger_en = cfg0_ff[3:0] == `CSR_MODE_CHG_BUCK;
    assign o_buck_en = (cfg0_ff[3:0] == `CSR_MODE_CHG_BUCK) ||
        (cfg0_ff[3:0] == `CSR_MODE_BUCK);
    assign otg_mode = (cfg0_ff[3:0] == `CSR_MODE_OTG) ||
        (cfg0_ff[3:0] == `CSR_MODE_OTG_E) ||
        (cfg0_ff[3:0] == `CSR_MODE_OTG_F);

    // ---------------------------------------------------------------
    // Qualification timers
    // ---------------------------------------------------------------

    // Input current held at its limit.
    csr_qualify #(.LIMIT(QUAL_LONG)) u_q_inlim (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cond(i_input_at_limit),
        .o_qual(qual_inlim)
    );

    // Battery overvoltage persists with a valid input.
    csr_qualify #(.LIMIT(QUAL_LONG)) u_q_ov (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cond(i_batt_overvolt && input_present),
        .o_qual(qual_ov)
    );

    // Battery overcurrent above threshold.
    csr_qualify #(.LIMIT(QUAL_SHORT)) u_q_oc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cond(i_batt_overcurrent),
        .o_qual(qual_oc)
    );

    // Boost converter current limit persistence.
    csr_qualify #(.LIMIT(QUAL_LONG)) u_q_boost (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cond(i_boost_ilim),
        .o_qual(qual_boost)
    );

    // Overcurrent seen since the last battery detail read.
    csr_sticky u_oc_seen (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(qual_oc),
        .i_clr(rd_det1),
        .o_flag(batt_oc_seen_w)
    );

    // ---------------------------------------------------------------
    // Bypass detail bits
    // ---------------------------------------------------------------

    // Switch limit latched in output modes until detail read.
    csr_sticky u_byp0 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(i_otg_ilim && otg_mode),
        .i_clr(rd_det2),
        .o_flag(byp_code[0])
    );

    // Buck negative limit latched until detail read.
    csr_sticky u_byp2 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_set(i_buck_neg_ilim),
        .i_clr(rd_det2),
        .o_flag(byp_code[2])
    );

    assign byp_code[1] = qual_boost;
    assign byp_code[3] = i_boost_done &&
        (cfg0_ff[3:0] == `CSR_MODE_BOOST);

    // ---------------------------------------------------------------
    // Detail codes
    // ---------------------------------------------------------------

    // Deep suspend hides the input from the battery logic.
    assign input_present = (i_input_detail_code == `CSR_INPUT_VALID) &&
        !i_deep_suspend;

    // Battery detail code selection, most severe condition first.
    always @* begin
        if (batt_oc_seen_w) begin
            bat_code = `CSR_BAT_OVERC;
        end else if (!input_present) begin
            bat_code = `CSR_BAT_ONLY;
        end else if (i_batt_removed && !cfg0_ff[4]) begin
            bat_code = `CSR_BAT_REMOVED;
        end else if (qual_ov) begin
            bat_code = `CSR_BAT_OVERV;
        end else if (i_batt_timer_fault) begin
            bat_code = 3'h2;
        end else if (i_batt_prequal) begin
            bat_code = 3'h1;
        end else if (i_batt_low) begin
            bat_code = `CSR_BAT_LOW;
        end else begin
            bat_code = `CSR_BAT_REGULAR;
        end
    end

    // Charger detail code; suspend reasons override the state code.
    always @* begin
        if (i_suspend_pin) begin
            chg_code = `CSR_CHG_SUSPEND;
        end else if (i_batt_disconnect_pin || i_batt_switch_disable_bit) begin
            chg_code = `CSR_CHG_SW_OFF;
        end else if (i_batt_removed && !cfg0_ff[4]) begin
            chg_code = `CSR_CHG_REMOVED;
        end else if (i_watchdog_expired) begin
            chg_code = `CSR_CHG_WDOG;
        end else if (i_guideline_ctrl) begin
            chg_code = `CSR_CHG_GUIDE;
        end else begin
            chg_code = i_charge_state_code;
        end
    end

    assign det0 = {1'b0, i_input_detail_code, 2'h0,
        i_remote_sense_detail, 1'b0};
    assign det1 = {i_thermal_regulation_flag, bat_code,
        chg_code};
    assign det2 = {1'b0, i_thermistor_detail_code, byp_code};

    // ---------------------------------------------------------------
    // Live status and interrupt latches
    // ---------------------------------------------------------------

    assign live[7] = !i_aicl_active;
    assign live[6] = i_input_detail_code == `CSR_INPUT_VALID;
    assign live[5] = !qual_inlim;
    assign live[4] = !(i_charge_suspended ||
        i_thermal_regulation_flag);
    assign live[3] = (bat_code == `CSR_BAT_REGULAR) ||
        (bat_code == `CSR_BAT_LOW) ||
        (bat_code == `CSR_BAT_ONLY);
    assign live[2] = 1'b0;
    assign live[1] = !i_batt_disconnect_pin;
    assign live[0] = byp_code == 4'h0;

    // Previous status, used to detect changes after reset settles.
    always @(posedge i_clk) begin
        if (i_rst) begin
            live_prev_ff <= 8'h00;
            live_init_ff <= 1'b0;
        end else begin
            live_prev_ff <= live;
            live_init_ff <= 1'b1;
        end
    end

    // One latch per status bit; the spare position never sets.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_latch
            csr_sticky u_lat (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_set(live_init_ff && g != 2 &&
                    (live[g] != live_prev_ff[g])),
                .i_clr(rd_latch),
                .o_flag(latch[g])
            );
        end
    endgenerate

    assign o_irq = |(latch & ~irq_mask_ff);

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------

    // Registered read data; unmapped addresses return zero.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `CSR_ADDR_IRQ_LATCH: o_rdata <= latch;
                `CSR_ADDR_IRQ_MASK: o_rdata <= irq_mask_ff;
                `CSR_ADDR_LIVE: o_rdata <= live;
                `CSR_ADDR_DET0: o_rdata <= det0;
                `CSR_ADDR_DET1: o_rdata <= det1;
                `CSR_ADDR_DET2: o_rdata <= det2;
                `CSR_ADDR_CFG0: o_rdata <= cfg0_ff;
                default: o_rdata <= 8'h00;
            endcase
        end
    end
endmodule // csr_charger_status

/* design/csr_regs.vh */
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
`define CSR_ADDR_IRQ_LATCH 8'h10
`define CSR_ADDR_IRQ_MASK 8'h11
`define CSR_ADDR_LIVE 8'h12
`define CSR_ADDR_DET0 8'h13
`define CSR_ADDR_DET1 8'h14
`define CSR_ADDR_DET2 8'h15
`define CSR_ADDR_CFG0 8'h16
`define CSR_RST_IRQ_MASK 8'hFF
`define CSR_RST_CFG0 8'h04
`define CSR_INPUT_VALID 2'h3
`define CSR_BAT_REMOVED 3'h0
`define CSR_BAT_REGULAR 3'h3
`define CSR_BAT_LOW 3'h4
`define CSR_BAT_OVERV 3'h5
`define CSR_BAT_OVERC 3'h6
`define CSR_BAT_ONLY 3'h7
`define CSR_CHG_SW_OFF 4'h7
`define CSR_CHG_WDOG 4'hB
`define CSR_CHG_GUIDE 4'hC
`define CSR_CHG_REMOVED 4'hD
`define CSR_CHG_SUSPEND 4'hE
`define CSR_MODE_BUCK 4'h4
`define CSR_MODE_CHG_BUCK 4'h5
`define CSR_MODE_BOOST 4'h9
`define CSR_MODE_OTG 4'hA
`define CSR_MODE_OTG_E 4'hE
`define CSR_MODE_OTG_F 4'hF
`define CSR_CLK_MHZ 250
`define CSR_QUAL_LONG_MS 30
`define CSR_QUAL_SHORT_MS 3
`define CSR_QUAL_LONG_CYC (`CSR_QUAL_LONG_MS * 1000 * `CSR_CLK_MHZ)
`define CSR_QUAL_SHORT_CYC (`CSR_QUAL_SHORT_MS * 1000 * `CSR_CLK_MHZ)
`define CSR_CNT_W 23
`endif

/* design/csr_qualify.v */
`timescale 1ns/1ns
`include "csr_regs.vh"
// Qualifies a level: output rises once input held for LIMIT cycles.
module csr_qualify #(
    parameter [22:0] LIMIT = 23'h000001
) (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst,
    // Condition in and qualified level out.
    input wire i_cond,
    output reg o_qual
);
    reg [22:0] cnt_ff;

    // Count while the condition holds; restart on any drop.
    always @(posedge i_clk) begin
        if (i_rst || !i_cond) begin
            cnt_ff <= 23'h000000;
            o_qual <= 1'b0;
        end else if (cnt_ff >= LIMIT - 23'h000001) begin
            o_qual <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 23'h000001;
        end
    end
endmodule // csr_qualify

/* design/csr_sticky.v */
`timescale 1ns/1ns
// Sticky flag: set wins over a clear in the same cycle.
module csr_sticky (
    // Clock and reset.
    input wire i_clk,
    input wire i_rst,
    // Set and clear strobes.
    input wire i_set,
    input wire i_clr,
    output reg o_flag
);
    // Hold the flag until cleared; a new set beats the clear.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule // csr_sticky

/* dv/csr_host.sv */
`timescale 1ns/1ns
// ----------------
// Host model on the register port
// ----------------
module csr_host (
    // Clock in.
    input wire i_clk,
    // Register port strobes out.
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    // Idle bus before the first access.
    initial begin
        o_addr = 8'hFF;
        o_wdata = 8'hFF;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // One access held over one sampling edge; on release the strobes drop and address and data are inverted.
    task automatic access(input logic w, input logic [7:0] a, d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = w;
        o_rd = !w;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
endmodule // csr_host

/* dv/csr_charger_status_chk.sv */
`timescale 1ns/1ns
// ----------------
// Checker of the charger status bank
// ----------------
module csr_chk (
    // Clock, reset and register port.
    input wire i_clk,
    input wire i_rst,
    input wire [7:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    // Conditions behind the checked fields.
    input wire i_aicl_active,
    input wire [1:0] i_input_detail_code,
    input wire i_thermal_regulation_flag,
    input wire i_batt_disconnect_pin,
    input wire i_batt_switch_disable_bit,
    input wire [1:0] i_remote_sense_detail,
    input wire [2:0] i_thermistor_detail_code,
    // Configuration and interrupt outputs.
    input wire [1:0] o_spread_envelope_sel,
    input wire o_spread_pattern_sel,
    input wire o_removal_detect_mask,
    input wire o_charger_en,
    input wire o_buck_en,
    input wire o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire [10:0] cond_w = {i_aicl_active, i_input_detail_code,
        i_thermal_regulation_flag, i_batt_disconnect_pin,
        i_batt_switch_disable_bit, i_remote_sense_detail,
        i_thermistor_detail_code};
    reg [10:0] cond_ff;
    reg [1:0] quiet_ff;
    reg [7:0] mask_ff;
    reg [7:0] cfg_ff;
    wire rd12 = i_rd && i_addr == 8'h12 && quiet_ff[1];
    wire rd13 = i_rd && i_addr == 8'h13 && quiet_ff[1];
    wire rd14 = i_rd && i_addr == 8'h14 && quiet_ff[1];
    wire rd15 = i_rd && i_addr == 8'h15 && quiet_ff[1];

    // Mirrors of the writable registers; quiet counts settled cycles.
    always @(posedge i_clk) begin
        cond_ff <= cond_w;
        if (i_rst) begin
            mask_ff <= 8'hFF;
            cfg_ff <= 8'h04;
            quiet_ff <= 2'h0;
        end else begin
            if (i_wr && i_addr == 8'h11) mask_ff <= i_wdata;
            if (i_wr && i_addr == 8'h16) cfg_ff <= i_wdata;
            if (cond_w != cond_ff) quiet_ff <= 2'h0;
            else if (quiet_ff != 2'h3) quiet_ff <= quiet_ff + 2'h1;
        end
    end

    chk_mask_readback:
    assert property (i_rd && !i_wr && i_addr == 8'h11 |=> o_rdata == mask_ff)
        else $error("mask readback wrong");
    chk_adaptive_bit:
    assert property (rd12 |=> o_rdata[7] == !$past(i_aicl_active))
        else $error("adaptive limit bit wrong");
    chk_valid_bit:
    assert property (rd12 |=>
        o_rdata[6] == ($past(i_input_detail_code) == 2'h3))
        else $error("input valid bit wrong");
    chk_disconnect_bit:
    assert property (rd12 && !i_batt_switch_disable_bit
        |=> o_rdata[1] == !$past(i_batt_disconnect_pin))
        else $error("disconnect bit wrong");
    chk_input_fields:
    assert property (rd13 |=> o_rdata[6:5] == $past(i_input_detail_code)
        && o_rdata[2:1] == $past(i_remote_sense_detail))
        else $error("input detail fields wrong");
    chk_thermal_flag:
    assert property (rd14 |=> o_rdata[7] == $past(i_thermal_regulation_flag))
        else $error("thermal flag wrong");
    chk_thermistor_field:
    assert property (rd15 |-> ##1
        o_rdata[6:4] == $past(i_thermistor_detail_code))
        else $error("thermistor field wrong");
    chk_mode_decode:
    assert property (o_charger_en == (cfg_ff[3:0] == 4'h5) &&
        (cfg_ff[3:0] > 4'h5 || o_buck_en == (cfg_ff[3:1] == 3'h2)))
        else $error("mode decode wrong");
    chk_config_bits:
    assert property ({o_spread_envelope_sel, o_spread_pattern_sel,
        o_removal_detect_mask} == cfg_ff[7:4])
        else $error("config outputs wrong");
    chk_irq_masked:
    assert property (mask_ff == 8'hFF |-> !o_irq)
        else $error("interrupt while all masked");

    // Main scenarios reached.
    cover property (o_irq);
    cover property (o_charger_en);
    cover property (rd14 ##1 o_rdata[6:4] == 3'h6);
endmodule // csr_chk

bind csr_charger_status csr_chk u_chk (.i_clk, .i_rst, .i_addr, .i_wr,
    .i_rd, .i_wdata, .o_rdata, .i_aicl_active, .i_input_detail_code,
    .i_thermal_regulation_flag, .i_batt_disconnect_pin,
    .i_batt_switch_disable_bit, .i_remote_sense_detail,
    .i_thermistor_detail_code, .o_spread_envelope_sel, .o_spread_pattern_sel,
    .o_removal_detect_mask, .o_charger_en, .o_buck_en, .o_irq);

/* dv/tb.sv */
`timescale 1ns/1ns
// ----------------
// Testbench of the charger status bank
// ----------------
module tb;
    localparam logic [22:0] QL = 23'h000014;
    localparam logic [22:0] QS = 23'h000005;
    localparam logic [31:0] B = 32'h02020006;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [31:0] c = 32'h0;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, rd, pat, rmsk, chg_en, buck_en, irq;
    logic [1:0] env;
    logic rd_p = 1'b0;
    logic [23:0] n;
    logic [23:0] notes[$];
    int fail_count = 0;
    int checks = 0;
    int pos[5] = '{23, 7, 10, 21, 22};
    logic [3:0] cd[5] = '{4'hE, 4'h7, 4'hD, 4'hB, 4'hC};

    csr_host host (.i_clk(i_clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata));
    csr_charger_status #(.QUAL_LONG(QL), .QUAL_SHORT(QS)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .o_rdata(rdata), .i_aicl_active(c[0]),
        .i_input_detail_code(c[2:1]), .i_input_at_limit(c[3]),
        .i_charge_suspended(c[4]), .i_thermal_regulation_flag(c[5]),
        .i_batt_disconnect_pin(c[6]), .i_batt_switch_disable_bit(c[7]),
        .i_remote_sense_detail(c[9:8]), .i_batt_removed(c[10]),
        .i_batt_timer_fault(c[11]), .i_batt_prequal(c[12]),
        .i_batt_low(c[13]), .i_batt_overvolt(c[14]),
        .i_batt_overcurrent(c[15]), .i_deep_suspend(c[16]),
        .i_charge_state_code(c[20:17]), .i_watchdog_expired(c[21]),
        .i_guideline_ctrl(c[22]), .i_suspend_pin(c[23]),
        .i_thermistor_detail_code(c[26:24]), .i_otg_ilim(c[27]),
        .i_boost_ilim(c[28]), .i_buck_neg_ilim(c[29]),
        .i_boost_done(c[30]), .o_spread_envelope_sel(env),
        .o_spread_pattern_sel(pat), .o_removal_detect_mask(rmsk),
        .o_charger_en(chg_en), .o_buck_en(buck_en), .o_irq(irq));

    // Free-running clock.
    initial forever #2 i_clk = ~i_clk;

    task automatic cmp(input string s, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask

    // A read notes address, expected value and mask before it starts.
    task automatic rdc(input logic [7:0] a, e, m);
        notes.push_back({a, e, m});
        host.access(1'b0, a, 8'h00);
    endtask

    task automatic put(input logic [31:0] x);
        @(posedge i_clk);
        #1;
        c = x;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic finish_test;
        if (notes.size() != 0) fail_count++;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Each read answer is matched against the oldest note.
    always @(posedge i_clk) begin
        if (rd_p) begin
            n = notes.pop_front();
            cmp($sformatf("reg %h", n[23:16]), n[15:8] & n[7:0], rdata & n[7:0]);
        end
        rd_p <= rd;
    end

    // Guard against a hang.
    initial begin
        #400000;
        fail_count++;
        finish_test;
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h6DB4FBAD));
        repeat (20) @(posedge i_clk);
        #1 i_rst = 1'b0;
        rdc(8'h11, 8'hFF, 8'hFF);
        rdc(8'h16, 8'h04, 8'hFF);
        rdc(8'h12, 8'hBB, 8'hFF);
        rdc(8'h20, 8'h00, 8'hFF);
        repeat (8) begin
            put($urandom & 32'h070E0377);
            rdc(8'h12, {~c[0], c[2:1] == 2'h3, 1'b1,
                ~(c[4] | c[5]),
                4'hB ^ {3'h0, c[6]} << 1}, (c[6] | c[19]) ? 8'hEF : 8'hFF);
            rdc(8'h13, {1'b0, c[2:1], 2'h0, c[9:8], 1'b0}, 8'hFF);
            rdc(8'h14, {c[5], c[2:1] == 2'h3 ? 3'h3 : 3'h7,
                c[6] ? 4'h7 : c[20:17]}, 8'hFF);
            rdc(8'h15, {1'b0, c[26:24], 4'h0}, 8'hFF);
        end
        put(B | 32'h8);
        rdc(8'h12, 8'h20, 8'h20);
        repeat (QL) @(posedge i_clk);
        rdc(8'h12, 8'h00, 8'h20);
        put(B | 32'h4000);
        rdc(8'h14, 8'h31, 8'h7F);
        repeat (QL) @(posedge i_clk);
        rdc(8'h14, 8'h51, 8'h7F);
        put(B & ~32'h4 | 32'h4000);
        rdc(8'h14, 8'h70, 8'h70);
        put(B | 32'h8000);
        repeat (QS) @(posedge i_clk);
        put(B);
        rdc(8'h14, 8'h61, 8'h7F);
        rdc(8'h14, 8'h31, 8'h7F);
        put(B | 32'h10000);
        rdc(8'h14, 8'h70, 8'h70);
        for (int i = 0; i < 5; i++) begin
            put(B | 32'h1 << pos[i]);
            rdc(8'h14, {4'h0, cd[i]}, 8'h0F);
        end
        put(B | 32'h400);
        rdc(8'h14, 8'h00, 8'h70);
        host.access(1'b1, 8'h16, 8'h14);
        rdc(8'h14, 8'h30, 8'h70);
        for (int m = 0; m < 16; m++) begin
            v = 8'($urandom);
            v[3:0] = m[3:0];
            host.access(1'b1, 8'h16, v);
            rdc(8'h16, v, 8'hFF);
            cmp("charger enable", {7'h0, v[3:0] == 4'h5},
                {7'h0, chg_en});
            cmp("spread", {4'h0, v[7:4]},
                {4'h0, env, pat, rmsk});
            if (v[3:0] <= 4'h5) begin
                cmp("buck", {7'h0, v[3:1] == 3'h2},
                    {7'h0, buck_en});
            end
        end
        host.access(1'b1, 8'h16, 8'h04);
        put(B | 32'h08000000);
        put(B);
        rdc(8'h15, 8'h20, 8'h7F);
        host.access(1'b1, 8'h16, 8'h0A);
        put(B | 32'h08000000);
        put(B);
        rdc(8'h15, 8'h21, 8'h7F);
        rdc(8'h15, 8'h20, 8'h7F);
        put(B | 32'h20000000);
        put(B);
        rdc(8'h12, 8'h00, 8'h01);
        rdc(8'h15, 8'h24, 8'h7F);
        rdc(8'h15, 8'h20, 8'h7F);
        put(B | 32'h10000000);
        repeat (QL) @(posedge i_clk);
        rdc(8'h15, 8'h22, 8'h7F);
        put(B);
        rdc(8'h10, 8'h00, 8'h00);
        host.access(1'b1, 8'h11, 8'h7F);
        rdc(8'h11, 8'h7F, 8'hFF);
        put(B | 32'h40);
        cmp("irq masked", 8'h00, {7'h0, irq});
        put(B | 32'h41);
        cmp("irq raised", 8'h01, {7'h0, irq});
        rdc(8'h10, 8'h82, 8'hEF);
        cmp("irq cleared", 8'h00, {7'h0, irq});
        repeat (2) @(posedge i_clk);
        finish_test;
    end
endmodule // tb
